// File: hdl/fsp_params.svh
// Register offsets, field positions, reset values and timing counts
`ifndef FSP_PARAMS_SVH
`define FSP_PARAMS_SVH
// ==========================================================
// Register offsets within the block window
`define FSP_BLOCK_BASE 32'h0000_4000
`define FSP_OFF_DATA 5'h00
`define FSP_OFF_IER 5'h01
`define FSP_OFF_IIR 5'h02
`define FSP_OFF_LCR 5'h03
`define FSP_OFF_MCR 5'h04
`define FSP_OFF_LSR 5'h05
`define FSP_OFF_MSR 5'h06
`define FSP_OFF_SCR 5'h07
`define FSP_OFF_CTL 5'h10
// ==========================================================
// Field positions
`define FSP_LCR_DIV_ACCESS 7
`define FSP_LCR_BREAK 6
`define FSP_LCR_STICK 5
`define FSP_LCR_EVEN 4
`define FSP_LCR_PAR_EN 3
`define FSP_LCR_STOP 2
`define FSP_MCR_AUX2 3
`define FSP_MCR_LOOP 4
`define FSP_FCR_EN 0
`define FSP_FCR_RX_CLR 1
`define FSP_FCR_TX_CLR 2
`define FSP_CTL_SRC 0
`define FSP_IER_RDA 0
`define FSP_IER_TX_HOLDING_EMPTY 1
`define FSP_IER_LS 2
// ==========================================================
// Reset values and identifiers
`define FSP_RST_BYTE 8'h00
`define FSP_RST_DIV 16'h0000
`define FSP_IID_LS 3'h3
`define FSP_IID_RDA 3'h2
`define FSP_IID_TO 3'h6
`define FSP_IID_TX_HOLDING_EMPTY 3'h1
`define FSP_IID_NONE 3'h0
// ==========================================================
// Timing and sizes
`define FSP_FIFO_DEPTH 16
`define FSP_TICKS_PER_BIT 16
`define FSP_TO_CHARS 4
`define FSP_TRIG0 5'd1
`define FSP_TRIG1 5'd4
`define FSP_TRIG2 5'd8
`define FSP_TRIG3 5'd14
`endif

// File: hdl/fsp_pkg.sv
// Types shared by the serial port design
package fsp_pkg;
   // ==========================================================
   // Register bus request
   typedef struct packed {
      logic rd;
      logic wr;
      logic [4:0] addr;
      logic [7:0] wdata;
   } fsp_bus_req_s;

   // ==========================================================
   // Serial engine states
   typedef enum logic [4:0] {
      FSP_IDLE = 5'b00001,
      FSP_START = 5'b00010,
      FSP_DATA = 5'b00100,
      FSP_PAR = 5'b01000,
      FSP_STOP = 5'b10000
   } fsp_state_e;

   // Received word with its line errors
   typedef struct packed {
      logic brk;
      logic fe;
      logic pe;
      logic [7:0] data;
   } fsp_rx_word_s;
endpackage

// File: hdl/fsp_serial_port.sv
// Serial port with FIFOs, baud generator and registers
`timescale 1ns/1ps
`include "fsp_params.svh"

// ==========================================================
// Synchronous FIFO with valid/ready on both sides
module fsp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic core_clk, // Block clock
   input wire logic resetn, // Async reset, active low
   input wire logic clear, // Drop all contents
   input wire logic in_valid, // Write request
   input wire logic [WIDTH-1:0] in_data, // Write data
   output logic in_ready, // Room available
   output logic out_valid, // Data available
   output logic [WIDTH-1:0] out_data, // Head entry
   input wire logic out_ready, // Pop request
   output logic [$clog2(DEPTH+1)-1:0] level // Entries held
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [CW-1:0] cnt_r;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   wire [AW-1:0] wp_nxt = (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
   wire [AW-1:0] rp_nxt = (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
   assign in_ready = cnt_r != CW'(DEPTH);
   assign out_valid = cnt_r != '0;
   assign out_data = mem[rp_r];
   assign level = cnt_r;
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wp_r] <= in_data;
      end
   end
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else if (clear) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) wp_r <= wp_nxt;
         if (pop) rp_r <= rp_nxt;
         cnt_r <= cnt_r + CW'(push) - CW'(pop);
      end
   end
endmodule // fsp_fifo

// Summary of operation
// R1: Port control bit picks fast or slow baud source.
// R2: Fast source: rates 50 to 115.2K baud.
// R3: Slow source: rates 125K to 1000K baud.
// R4: Start, 5 to 8 data, optional parity, 1/1.5/2 stops.
// R5: Selected source divided by 16-bit divisor 1..65535.
// R6: Interrupt output only while aux output two is set.
// R7: Byte written to holding register or FIFO is framed, sent.
// R8: Start, data LSB first, parity, stop; sixteen ticks per bit.
// R9: Holding-empty interrupt when transmit store empties.
// R10: FIFO mode buffers 16 TX bytes, sends until empty.
// R11: Receiver samples at 16x; rejects pulses under two ticks.
// R12: Received char to buffer/FIFO, first bit in bit 0; checked.
// R13: Interrupts on data, timeout, parity, framing, line errors.
// R14: FIFO mode holds 16 RX bytes; data interrupt at 1/4/8/14.
// R15: Without power enable the block stays idle.
// R16: Logic runs on core clock, apart from baud sources.
// R17: Interrupt identify resets to bit 0 high, others low.
// R18: Line state resets to bits 5 and 6 set; IRQ_ENABLE_REG and LINE_FORMAT reset zero.
// R19: Interrupt output is a level, active high.
// R20: Registers at 0x00 to 0x07 and port control at 0x10.
// R21: Divisor access bit maps 0x00/0x01 to divisor low/high bytes.
// R22: DMA mode select bit has no effect.
// R23: FIFO-only status bits read zero in non-FIFO mode.
// R24: Timeout after four idle character times with data held.
module fsp_serial_port
   import fsp_pkg::*;
(
   input wire logic core_clk, // Block clock
   input wire logic resetn, // Async reset, active low
   input wire logic dev_power_en, // Power enable from clock enables
   input wire logic baud_src_fast, // Fast baud source level
   input wire logic baud_src_slow, // Slow baud source level
   input wire fsp_bus_req_s bus_req, // Register request
   output logic [7:0] bus_rdata, // Read data, one cycle after rd
   output logic group_irq_four, // Interrupt request
   output logic serial_tx, // Serial transmit pin
   input wire logic serial_rx // Serial receive pin
);
   localparam int CW = $clog2(`FSP_FIFO_DEPTH+1);

   // ==========================================================
   // Registers
   logic [7:0] lcr_r, scr_r, rdata_r;
   logic [3:0] ier_r;
   logic [4:0] mcr_r;
   logic [15:0] div_r, div_cnt_r;
   logic src_sel_r, fifo_en_r, src_q_r, irq_r, pin_r;
   logic [1:0] trig_r;
   logic oe_r, pe_r, fe_r, bi_r, tx_holding_empty_r, tx_empty_q_r;
   logic [9:0] to_cnt_r;

   // ==========================================================
   // Register decode
   wire dla = lcr_r[`FSP_LCR_DIV_ACCESS]; // R21
   wire wr = bus_req.wr;
   wire rd = bus_req.rd;
   wire [4:0] a = bus_req.addr;
   wire [7:0] wd = bus_req.wdata;
   wire wr_thr = wr && a == `FSP_OFF_DATA && !dla; // R20
   wire wr_dll = wr && a == `FSP_OFF_DATA && dla; // R21
   wire wr_dlm = wr && a == `FSP_OFF_IER && dla; // R21
   wire wr_ier = wr && a == `FSP_OFF_IER && !dla;
   wire wr_fcr = wr && a == `FSP_OFF_IIR;
   wire rd_rbr = rd && a == `FSP_OFF_DATA && !dla;
   wire rd_iir = rd && a == `FSP_OFF_IIR;
   wire rd_lsr = rd && a == `FSP_OFF_LSR;
   wire loop = mcr_r[`FSP_MCR_LOOP];
   wire [1:0] wl = lcr_r[1:0];
   wire pen = lcr_r[`FSP_LCR_PAR_EN];
   wire eps = lcr_r[`FSP_LCR_EVEN];
   wire stick = lcr_r[`FSP_LCR_STICK];
   wire [7:0] wmask = 8'hFF >> (2'd3 - wl);
   wire [2:0] last_bit = 3'd4 + {1'b0, wl};
   // Toggling FIFO enable flushes both FIFOs
   wire fen_chg = wr_fcr && (wd[`FSP_FCR_EN] != fifo_en_r);
   wire rx_clr = wr_fcr && (wd[`FSP_FCR_RX_CLR] || fen_chg);
   wire tx_clr = wr_fcr && (wd[`FSP_FCR_TX_CLR] || fen_chg);

   // ==========================================================
   // Baud generator
   // One tick per rising source edge seen by core clock
   wire src_lvl = src_sel_r ? baud_src_slow : baud_src_fast; // R1 R2 R3
   wire src_tick = src_lvl && !src_q_r && dev_power_en; // R15 R16
   wire div_hit = div_r != '0 && div_cnt_r >= div_r - 16'h0001;
   wire tick = src_tick && div_hit; // R5

   // ==========================================================
   // Transmit path
   fsp_state_e tx_st_r;
   logic [7:0] tx_sh_r;
   logic [2:0] tx_bit_r;
   logic [4:0] tx_cnt_r;
   logic tx_par_r;
   logic [7:0] txf_data;
   logic txf_valid, txf_in_ready;
   logic [CW-1:0] tx_lvl;
   // Non-FIFO mode: FIFO acts as one holding register
   wire thr_room = fifo_en_r ? txf_in_ready : tx_lvl == '0; // R10
   wire tx_load = tx_st_r == FSP_IDLE && txf_valid && dev_power_en; // R7
   wire [7:0] tx_byte = txf_data & wmask;
   wire tx_par_bit = stick ? !eps : (eps ? ^tx_byte : !(^tx_byte)); // R4
   wire [4:0] stop_end = !lcr_r[`FSP_LCR_STOP] ? 5'd15 :
                         (wl == 2'd0 ? 5'd23 : 5'd31); // R4
   wire tx_bit_end = tick && tx_cnt_r == 5'd15;
   logic tx_ser;
   always_comb begin
      case (tx_st_r)
         FSP_START: tx_ser = 1'b0;
         FSP_DATA: tx_ser = tx_sh_r[0]; // R8
         FSP_PAR: tx_ser = tx_par_r;
         default: tx_ser = 1'b1;
      endcase
   end

   fsp_fifo #(.WIDTH(8), .DEPTH(`FSP_FIFO_DEPTH)) u_tx_fifo (
      .core_clk(core_clk),
      .resetn(resetn),
      .clear(tx_clr),
      .in_valid(wr_thr && thr_room),
      .in_data(wd),
      .in_ready(txf_in_ready),
      .out_valid(txf_valid),
      .out_data(txf_data),
      .out_ready(tx_load),
      .level(tx_lvl)
   );

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         tx_st_r <= FSP_IDLE;
         tx_sh_r <= `FSP_RST_BYTE;
         tx_bit_r <= '0;
         tx_cnt_r <= '0;
         tx_par_r <= 1'b0;
      end else if (!dev_power_en) begin
         tx_st_r <= FSP_IDLE; // R15
      end else begin
         if (tick) tx_cnt_r <= (tx_bit_end && tx_st_r != FSP_STOP) ? '0 : tx_cnt_r + 5'd1;
         case (tx_st_r)
            FSP_IDLE: begin
               if (tx_load) begin
                  tx_sh_r <= tx_byte;
                  tx_par_r <= tx_par_bit;
                  tx_cnt_r <= '0;
                  tx_st_r <= FSP_START;
               end
            end
            FSP_START: begin
               if (tx_bit_end) begin
                  tx_bit_r <= '0;
                  tx_st_r <= FSP_DATA;
               end
            end
            FSP_DATA: begin
               if (tx_bit_end) begin
                  tx_sh_r <= tx_sh_r >> 1; // R8
                  tx_bit_r <= tx_bit_r + 3'd1;
                  if (tx_bit_r == last_bit) tx_st_r <= pen ? FSP_PAR : FSP_STOP;
               end
            end
            FSP_PAR: begin
               if (tx_bit_end) tx_st_r <= FSP_STOP;
            end
            FSP_STOP: begin
               if (tick && tx_cnt_r == stop_end) tx_st_r <= FSP_IDLE;
            end
            default: tx_st_r <= FSP_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Receive path
   fsp_state_e rx_st_r;
   logic rx_s1_r, rx_filt_r, rx_zero_r, rx_pe_r;
   logic [7:0] rx_sh_r;
   logic [2:0] rx_bit_r;
   logic [4:0] rx_cnt_r;
   fsp_rx_word_s rxf_data, rx_word;
   logic rxf_valid, rxf_in_ready;
   logic [CW-1:0] rx_lvl;
   // Loopback feeds transmit stream back in
   wire rx_in = loop ? tx_ser : serial_rx;
   wire rx_mid = tick && rx_cnt_r == 5'd15;
   wire [7:0] rx_data = rx_sh_r >> (2'd3 - wl); // R12
   wire rx_par_exp = stick ? !eps : (eps ? ^rx_data : !(^rx_data));
   wire rx_push = rx_st_r == FSP_STOP && rx_mid;
   wire rx_room = fifo_en_r ? rxf_in_ready : rx_lvl == '0; // R14
   wire rx_pop = rd_rbr && rxf_valid;
   always_comb begin
      rx_word.data = rx_data;
      rx_word.pe = rx_pe_r; // R12
      rx_word.fe = !rx_filt_r; // R12
      rx_word.brk = rx_zero_r && !rx_filt_r;
   end

   fsp_fifo #(.WIDTH(11), .DEPTH(`FSP_FIFO_DEPTH)) u_rx_fifo (
      .core_clk(core_clk),
      .resetn(resetn),
      .clear(rx_clr),
      .in_valid(rx_push && rx_room),
      .in_data(rx_word),
      .in_ready(rxf_in_ready),
      .out_valid(rxf_valid),
      .out_data(rxf_data),
      .out_ready(rd_rbr),
      .level(rx_lvl)
   );

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rx_st_r <= FSP_IDLE;
         rx_s1_r <= 1'b1;
         rx_filt_r <= 1'b1;
         rx_sh_r <= `FSP_RST_BYTE;
         rx_bit_r <= '0;
         rx_cnt_r <= '0;
         rx_zero_r <= 1'b0;
         rx_pe_r <= 1'b0;
      end else if (!dev_power_en) begin
         rx_st_r <= FSP_IDLE; // R15
      end else begin
         if (tick) begin
            rx_s1_r <= rx_in; // R11
            // Level must hold two ticks to pass
            if (rx_in == rx_s1_r) rx_filt_r <= rx_in; // R11
            rx_cnt_r <= rx_mid ? '0 : rx_cnt_r + 5'd1;
         end
         case (rx_st_r)
            FSP_IDLE: begin
               if (tick && !rx_filt_r) begin
                  rx_cnt_r <= '0;
                  rx_zero_r <= 1'b1;
                  rx_st_r <= FSP_START;
               end
            end
            FSP_START: begin
               if (tick && rx_cnt_r == 5'd7) begin
                  rx_cnt_r <= '0;
                  rx_bit_r <= '0;
                  rx_st_r <= rx_filt_r ? FSP_IDLE : FSP_DATA;
               end
            end
            FSP_DATA: begin
               if (rx_mid) begin
                  rx_sh_r <= {rx_filt_r, rx_sh_r[7:1]}; // R12
                  rx_zero_r <= rx_zero_r && !rx_filt_r;
                  rx_bit_r <= rx_bit_r + 3'd1;
                  if (rx_bit_r == last_bit) begin
                     rx_pe_r <= 1'b0;
                     rx_st_r <= pen ? FSP_PAR : FSP_STOP;
                  end
               end
            end
            FSP_PAR: begin
               if (rx_mid) begin
                  rx_pe_r <= rx_filt_r != rx_par_exp; // R12
                  rx_zero_r <= rx_zero_r && !rx_filt_r;
                  rx_st_r <= FSP_STOP;
               end
            end
            FSP_STOP: begin
               if (rx_mid) rx_st_r <= FSP_IDLE;
            end
            default: rx_st_r <= FSP_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Interrupt sources and identification
   wire [9:0] char_bits = 10'd7 + 10'(wl) + 10'(pen) + 10'(lcr_r[`FSP_LCR_STOP]);
   wire [9:0] to_limit = char_bits * 10'(`FSP_TO_CHARS * `FSP_TICKS_PER_BIT);
   wire to_hit = fifo_en_r && rx_lvl != '0 && to_cnt_r >= to_limit; // R24
   wire [4:0] trig_lvl = trig_r == 2'd0 ? `FSP_TRIG0 : trig_r == 2'd1 ? `FSP_TRIG1 :
                         trig_r == 2'd2 ? `FSP_TRIG2 : `FSP_TRIG3; // R14
   wire rda = fifo_en_r ? 5'(rx_lvl) >= trig_lvl : rx_lvl != '0; // R13
   wire ls_irq = ier_r[`FSP_IER_LS] && (oe_r || pe_r || fe_r || bi_r); // R13
   wire rda_irq = ier_r[`FSP_IER_RDA] && rda; // R13
   wire to_irq = ier_r[`FSP_IER_RDA] && to_hit; // R13
   wire tx_holding_empty_irq = ier_r[`FSP_IER_TX_HOLDING_EMPTY] && tx_holding_empty_r; // R9
   wire [2:0] iid = ls_irq ? `FSP_IID_LS : rda_irq ? `FSP_IID_RDA :
                    to_irq ? `FSP_IID_TO : tx_holding_empty_irq ? `FSP_IID_TX_HOLDING_EMPTY : `FSP_IID_NONE;
   wire pend = ls_irq || rda_irq || to_irq || tx_holding_empty_irq;
   wire tx_empty = tx_lvl == '0;
   wire tx_holding_empty_set = (tx_empty && !tx_empty_q_r) ||
                   (wr_ier && wd[`FSP_IER_TX_HOLDING_EMPTY] && !ier_r[`FSP_IER_TX_HOLDING_EMPTY] && tx_empty); // R9
   wire tx_holding_empty_clr = wr_thr || (rd_iir && iid == `FSP_IID_TX_HOLDING_EMPTY);
   wire rx_err = rx_push && (rx_word.pe || rx_word.fe || rx_word.brk);
   wire [7:0] irq_identify = {fifo_en_r, fifo_en_r, 2'b00, iid, !pend}; // R17 R23
   wire [7:0] line_state = {fifo_en_r && (pe_r || fe_r || bi_r), tx_empty && tx_st_r == FSP_IDLE,
                     tx_empty, bi_r, fe_r, pe_r, oe_r, rxf_valid}; // R18 R23
   wire [7:0] modem_state = loop ? {mcr_r[3], mcr_r[2], mcr_r[0], mcr_r[1], 4'h0} : 8'h00;

   // ==========================================================
   // Read selection
   logic [7:0] rd_mux;
   always_comb begin
      if (a == `FSP_OFF_DATA) begin
         rd_mux = dla ? div_r[7:0] : rxf_data.data; // R21
      end else if (a == `FSP_OFF_IER) begin
         rd_mux = dla ? div_r[15:8] : {4'h0, ier_r};
      end else if (a == `FSP_OFF_IIR) begin
         rd_mux = irq_identify;
      end else if (a == `FSP_OFF_LCR) begin
         rd_mux = lcr_r;
      end else if (a == `FSP_OFF_MCR) begin
         rd_mux = {3'b000, mcr_r};
      end else if (a == `FSP_OFF_LSR) begin
         rd_mux = line_state;
      end else if (a == `FSP_OFF_MSR) begin
         rd_mux = modem_state;
      end else if (a == `FSP_OFF_SCR) begin
         rd_mux = scr_r;
      end else if (a == `FSP_OFF_CTL) begin
         rd_mux = {7'h00, src_sel_r}; // R20
      end else begin
         rd_mux = 8'h00;
      end
   end

   // ==========================================================
   // Register file and status
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         lcr_r <= `FSP_RST_BYTE; // R18
         ier_r <= '0; // R18
         mcr_r <= '0;
         scr_r <= `FSP_RST_BYTE;
         div_r <= `FSP_RST_DIV;
         src_sel_r <= 1'b0;
         fifo_en_r <= 1'b0;
         trig_r <= 2'b00;
      end else begin
         if (wr && a == `FSP_OFF_LCR) lcr_r <= wd;
         if (wr_ier) ier_r <= wd[3:0];
         if (wr && a == `FSP_OFF_MCR) mcr_r <= wd[4:0];
         if (wr && a == `FSP_OFF_SCR) scr_r <= wd;
         if (wr && a == `FSP_OFF_CTL) src_sel_r <= wd[`FSP_CTL_SRC]; // R1
         if (wr_dll) div_r[7:0] <= wd; // R5
         if (wr_dlm) div_r[15:8] <= wd; // R5
         // DMA select bit is not stored
         if (wr_fcr) begin
            fifo_en_r <= wd[`FSP_FCR_EN]; // R10 R22
            trig_r <= wd[7:6];
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         src_q_r <= 1'b0;
         div_cnt_r <= '0;
         oe_r <= 1'b0;
         pe_r <= 1'b0;
         fe_r <= 1'b0;
         bi_r <= 1'b0;
         tx_holding_empty_r <= 1'b0;
         tx_empty_q_r <= 1'b1;
         to_cnt_r <= '0;
         irq_r <= 1'b0;
         pin_r <= 1'b1;
         rdata_r <= `FSP_RST_BYTE;
      end else begin
         src_q_r <= src_lvl;
         if (tick) div_cnt_r <= '0;
         else if (src_tick) div_cnt_r <= div_cnt_r + 16'h0001;
         // Set beats read clear in one cycle
         oe_r <= (rx_push && !rx_room) || (oe_r && !rd_lsr);
         pe_r <= (rx_err && rx_word.pe) || (pe_r && !rd_lsr); // R13
         fe_r <= (rx_err && rx_word.fe) || (fe_r && !rd_lsr); // R13
         bi_r <= (rx_err && rx_word.brk) || (bi_r && !rd_lsr);
         tx_holding_empty_r <= tx_holding_empty_set || (tx_holding_empty_r && !tx_holding_empty_clr); // R9
         tx_empty_q_r <= tx_empty;
         if (rx_push || rx_pop || rx_lvl == '0) to_cnt_r <= '0; // R24
         else if (tick && !to_hit) to_cnt_r <= to_cnt_r + 10'd1;
         irq_r <= pend && mcr_r[`FSP_MCR_AUX2]; // R6 R19
         // Loopback holds mark; break drives low
         pin_r <= loop ? 1'b1 : (lcr_r[`FSP_LCR_BREAK] ? 1'b0 : tx_ser); // R8
         if (rd) rdata_r <= rd_mux;
      end
   end

   assign bus_rdata = rdata_r;
   assign group_irq_four = irq_r;
   assign serial_tx = pin_r;
endmodule // fsp_serial_port

// File: sim/fsp_serial_port_chk.sv
// Concurrent checks on the serial port pins and register bus
`timescale 1ns/1ps
`include "fsp_params.svh"
// ==========================================================
// Checker
module fsp_serial_port_chk
   import fsp_pkg::*;
(
   input wire logic core_clk, // Clock
   input wire logic resetn, // Reset, low
   input wire logic dev_power_en, // Power enable
   input wire fsp_bus_req_s bus_req, // Request
   input wire logic [7:0] bus_rdata, // Read data
   input wire logic group_irq_four, // Interrupt
   input wire logic serial_tx // Tx pin
);
   logic aux2_r;
   logic [7:0] spare_r;
   logic [7:0] lcr_r;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // Shadows: read data judged from bus traffic alone
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         aux2_r <= 1'b0;
         spare_r <= 8'h00;
         lcr_r <= 8'h00;
      end else if (bus_req.wr) begin
         if (bus_req.addr == `FSP_OFF_MCR) aux2_r <= bus_req.wdata[`FSP_MCR_AUX2];
         if (bus_req.addr == `FSP_OFF_SCR) spare_r <= bus_req.wdata;
         if (bus_req.addr == `FSP_OFF_LCR) lcr_r <= bus_req.wdata;
      end
   end
   sequence s_rd(logic [4:0] a);
      bus_req.rd && bus_req.addr == a;
   endsequence
   sequence s_rd_hole;
      bus_req.rd && (bus_req.addr[3] || (bus_req.addr[4] && bus_req.addr != `FSP_OFF_CTL));
   endsequence
   a_reset_idle: assert property ($rose(resetn) |-> serial_tx && !group_irq_four)
      else $error("tx or irq active after reset");
   a_power_idle: assert property ((!dev_power_en) [*3] |-> serial_tx)
      else $error("tx active while powered down");
   a_start_len: assert property ($fell(serial_tx) |-> (!serial_tx) [*8])
      else $error("start bit too short");
   a_irq_gated: assert property (!aux2_r && !$past(aux2_r) |-> !group_irq_four)
      else $error("irq with aux output two clear");
   a_rdata_hold: assert property (!$past(bus_req.rd) |-> $stable(bus_rdata))
      else $error("read data changed without read");
   a_hole_zero: assert property (s_rd_hole |=> bus_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_spare_echo: assert property (s_rd(`FSP_OFF_SCR) |=> bus_rdata == $past(spare_r))
      else $error("spare byte readback wrong");
   a_lcr_echo: assert property (s_rd(`FSP_OFF_LCR) |=> bus_rdata == $past(lcr_r))
      else $error("line format readback wrong");
endmodule // fsp_serial_port_chk

// File: sim/fsp_partner.sv
// Remote serial partner model
`timescale 1ns/1ps
// ==========================================================
// Partner model
module fsp_partner #(
   parameter int BIT = 64 // Core cycles per bit
) (
   input wire logic core_clk, // Clock
   input wire logic line_in, // From device tx
   output logic line_out // To device rx, idle high
);
   logic [8:0] got[$];
   logic [7:0] b;
   initial line_out = 1'b1;
   task automatic hold(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // Mid-bit sampling; stop level kept in bit 8
   always begin
      @(negedge line_in);
      hold(BIT / 2);
      for (int i = 0; i < 8; i++) begin
         hold(BIT);
         b[i] = line_in;
      end
      hold(BIT);
      got.push_back({line_in, b});
   end
   // Raw bits, so a wrong parity can be sent
   task automatic send(input logic [9:0] d, input int n);
      hold(1);
      line_out = 1'b0;
      hold(BIT);
      for (int i = 0; i < n; i++) begin
         line_out = d[i];
         hold(BIT);
      end
      line_out = 1'b1;
      hold(BIT);
   endtask
   task automatic pulse(input int c);
      hold(1);
      line_out = 1'b0;
      hold(c);
      line_out = 1'b1;
   endtask
endmodule // fsp_partner

// File: sim/fsp_serial_port_tb.sv
// Self-checking bench for the serial port
`timescale 1ns/1ps
`include "fsp_params.svh"
// ==========================================================
// Bench
module fsp_serial_port_tb
   import fsp_pkg::*;
;
   logic core_clk, resetn, dev_power_en, baud_src_fast, baud_src_slow, serial_rx;
   logic group_irq_four, serial_tx;
   logic [7:0] bus_rdata, d;
   logic [7:0] e[6];
   fsp_bus_req_s bus_req;
   int fail_count, checks;
   fsp_serial_port dut (.core_clk, .resetn, .dev_power_en, .baud_src_fast, .baud_src_slow,
      .bus_req, .bus_rdata, .group_irq_four, .serial_tx, .serial_rx);
   // Fast source edge every 4 cycles: 64 cycles a bit at divisor 1
   fsp_partner #(.BIT(64)) p (.core_clk, .line_in(serial_tx), .line_out(serial_rx));
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   always #50 baud_src_fast = ~baud_src_fast;
   always #75 baud_src_slow = ~baud_src_slow;
   function automatic logic [7:0] irq_identify(logic [2:0] id);
      return {4'hc, id, 1'b0};
   endfunction
   function automatic logic [9:0] bad_par(logic [7:0] v);
      return {1'b0, ~^v, v};
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic chk(input string n, input logic [8:0] s, input logic [8:0] x);
      checks++;
      if (s !== x) begin
         fail_count++;
         $display("Error %s expected %h seen %h", n, x, s);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] v);
      cyc(1);
      bus_req = '{1'b0, 1'b1, a, v};
      cyc(1);
      bus_req = '0;
   endtask
   task automatic rc(input logic [4:0] a, input logic [7:0] x, input string n);
      cyc(1);
      bus_req = '{1'b1, 1'b0, a, 8'h00};
      cyc(1);
      bus_req = '0;
      chk(n, {1'b0, bus_rdata}, {1'b0, x});
   endtask
   task automatic wait_got(input int n);
      for (int k = 0; k < 20000 && p.got.size() < n; k++)
         @(posedge core_clk);
      cyc(64);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge core_clk);
      fail_count++;
      final_report();
   end
   // ==========================================================
   // Main sequence
   initial begin
      resetn = 1'b0;
      dev_power_en = 1'b1;
      bus_req = '0;
      baud_src_fast = 1'b0;
      baud_src_slow = 1'b0;
      void'($urandom(32'hb92c));
      repeat (16) @(posedge core_clk);
      #1 resetn = 1'b1;
      rc(`FSP_OFF_IIR, 8'h01, "iir");
      rc(`FSP_OFF_LSR, 8'h60, "lsr");
      rc(`FSP_OFF_IER, 8'h00, "ier");
      rc(`FSP_OFF_LCR, 8'h00, "lcr");
      rc(5'h08, 8'h00, "hole");
      rc(5'h1f, 8'h00, "hole");
      wr(`FSP_OFF_LCR, 8'h83);
      wr(`FSP_OFF_DATA, 8'h01);
      wr(`FSP_OFF_IER, 8'h5a);
      rc(`FSP_OFF_DATA, 8'h01, "div_lo");
      rc(`FSP_OFF_IER, 8'h5a, "div_hi");
      wr(`FSP_OFF_IER, 8'h00);
      wr(`FSP_OFF_LCR, 8'h03);
      rc(`FSP_OFF_IER, 8'h00, "ier");
      wr(`FSP_OFF_CTL, 8'h01);
      rc(`FSP_OFF_CTL, 8'h01, "ctl");
      wr(`FSP_OFF_CTL, 8'h00);
      d = 8'($urandom);
      wr(`FSP_OFF_SCR, d);
      rc(`FSP_OFF_SCR, d, "spare");
      $display("register test done");
      wr(`FSP_OFF_IER, 8'h02);
      wr(`FSP_OFF_MCR, 8'h08);
      wr(`FSP_OFF_IIR, 8'h49);
      for (int i = 0; i < 6; i++) begin
         e[i] = 8'($urandom);
         wr(`FSP_OFF_DATA, e[i]);
      end
      wait_got(6);
      for (int i = 0; i < 6; i++)
         chk("tx", p.got[i], {1'b1, e[i]});
      chk("irq", 9'(group_irq_four), 9'h001);
      wr(`FSP_OFF_MCR, 8'h00);
      cyc(1);
      chk("irq", 9'(group_irq_four), 9'h000);
      wr(`FSP_OFF_MCR, 8'h08);
      cyc(1);
      chk("irq", 9'(group_irq_four), 9'h001);
      rc(`FSP_OFF_IIR, irq_identify(`FSP_IID_TX_HOLDING_EMPTY), "iir");
      rc(`FSP_OFF_LSR, 8'h60, "lsr");
      $display("tx test done");
      wr(`FSP_OFF_IER, 8'h05);
      for (int i = 0; i < 4; i++) begin
         e[i] = 8'($urandom);
         p.send({2'b00, e[i]}, 8);
         if (i == 2) chk("irq", 9'(group_irq_four), 9'h000);
      end
      chk("irq", 9'(group_irq_four), 9'h001);
      rc(`FSP_OFF_IIR, irq_identify(`FSP_IID_RDA), "iir");
      for (int i = 0; i < 4; i++)
         rc(`FSP_OFF_DATA, e[i], "rx");
      wr(`FSP_OFF_LCR, 8'h1b);
      d = 8'($urandom);
      p.send(bad_par(d), 9);
      rc(`FSP_OFF_IIR, irq_identify(`FSP_IID_LS), "iir");
      rc(`FSP_OFF_LSR, 8'he5, "lsr");
      rc(`FSP_OFF_LSR, 8'h61, "lsr");
      rc(`FSP_OFF_DATA, d, "rx");
      $display("rx test done");
      wr(`FSP_OFF_LCR, 8'h03);
      d = 8'($urandom);
      p.send({2'b00, d}, 8);
      for (int k = 0; k < 6000 && group_irq_four !== 1'b1; k++)
         @(posedge core_clk);
      rc(`FSP_OFF_IIR, irq_identify(`FSP_IID_TO), "iir");
      rc(`FSP_OFF_DATA, d, "rx");
      p.pulse(3);
      cyc(700);
      rc(`FSP_OFF_LSR, 8'h60, "lsr");
      wr(`FSP_OFF_IIR, 8'h00);
      rc(`FSP_OFF_IIR, 8'h01, "iir");
      $display("timeout test done");
      dev_power_en = 1'b0;
      d = 8'($urandom);
      wr(`FSP_OFF_DATA, d);
      cyc(800);
      chk("count", 9'(p.got.size()), 9'd6);
      dev_power_en = 1'b1;
      wait_got(7);
      chk("tx", p.got[6], {1'b1, d});
      resetn = 1'b0;
      cyc(3);
      resetn = 1'b1;
      rc(`FSP_OFF_LCR, 8'h00, "lcr");
      rc(`FSP_OFF_IIR, 8'h01, "iir");
      $display("power test done");
      final_report();
   end
endmodule // fsp_serial_port_tb

bind fsp_serial_port fsp_serial_port_chk chk (.core_clk, .resetn, .dev_power_en, .bus_req,
   .bus_rdata, .group_irq_four, .serial_tx);
